// ---- bench/ckg_ctrl_regs_test.sv ----
// Self-checking bench of the clock generator control bank
`timescale 1ns/1ps
module ckg_ctrl_regs_test;
	import ckg_pkg::*;
	logic        clk, arst_n, strap, pgood, pdn, scl, pull, sda_out, sda_oe;
	logic [23:0] o; // All control outputs, strap first
	logic [7:0]  wd [8] = '{8'h60, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00};
	int          n_fail, check_count, cyc;
	wire         sda = ~(pull | sda_oe); // Pulled-up data line
	ckg_host_model ckg_host_model_i (.clk(clk), .scl(scl), .sda_pull(pull), .sda_line(sda));
	ckg_ctrl_regs ckg_ctrl_regs_i (.clk(clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .freq_strap(strap), .clk_power_good(pgood), .powerdown_n(pdn),
		.cpu_freq_is_100(o[23]), .mgmt_clock_mode(o[22]), .src_root_select(o[21]), .sata_root_select(o[20]),
		.powerdown_keep_config(o[19]), .pll_a_spread_type(o[18]), .pll_c_spread_type(o[17]),
		.pll_c_cfg_table(o[16:13]), .pll_c_cfg_apply(o[12]), .pll_a_spread_enable(o[11]),
		.pll_c_spread_enable(o[10]), .refclk_out_enable(o[9]), .sata_clk_out_enable(o[8]),
		.pcie_ref_out_enable(o[7]), .video96_out_enable(o[6]), .host_clk_b_out_enable(o[5]),
		.host_clk_a_out_enable(o[4]), .video27_plain_out_enable(o[3]), .video27_spread_out_enable(o[2]),
		.refclk_slew_mid(o[1]), .video27_slew_mid(o[0]));
	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
		check_count++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic finish_test();
		if (n_fail == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Send a byte, compare the ninth bit
	task automatic wr(input logic [7:0] d, input logic k);
		logic [7:0] q;
		logic       a;
		ckg_host_model_i.byte_x(d, 1'b1, q, a);
		chk("ack", {23'h0, k}, {23'h0, a});
	endtask
	task automatic rd(input logic [7:0] e, input logic last);
		logic [7:0] q;
		logic       a;
		ckg_host_model_i.byte_x(8'hff, last, q, a);
		chk("rdata", {16'h0, e}, {16'h0, q});
	endtask
	// Block read: count first, then bytes 0 to 8
	task automatic blk(input logic [8:0][7:0] e);
		ckg_host_model_i.cond(1'b0);
		wr(8'hd2, 1'b0);
		wr(8'h00, 1'b0);
		ckg_host_model_i.cond(1'b0);
		wr(8'hd3, 1'b0);
		rd(8'h0f, 1'b0);
		for (int i = 0; i < 9; i++)
			rd(e[i], i == 8);
		ckg_host_model_i.cond(1'b1);
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 95000) begin
			n_fail++;
			finish_test();
		end
	end
	initial begin
		arst_n = 1'b0;
		strap  = 1'b1;
		pgood  = 1'b0;
		pdn    = 1'b1;
		repeat (12) @(posedge clk);
		#1 arst_n = 1'b1;
		repeat (4) @(posedge clk);
		#1 pgood = 1'b1;
		repeat (8) @(posedge clk);
		#1 chk("pins", 24'h885ffc, o);
		blk({8'h63, 8'h35, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'h85, 8'ha1});
		ckg_host_model_i.cond(1'b0);
		wr(8'hd4, 1'b1);
		ckg_host_model_i.cond(1'b1);
		ckg_host_model_i.cond(1'b0);
		wr(8'hd2, 1'b0);
		wr(8'h80, 1'b0);
		wr(8'h16, 1'b0);
		ckg_host_model_i.cond(1'b1);
		chk("pins", 24'hf04ffc, o);
		ckg_host_model_i.cond(1'b0);
		wr(8'hd2, 1'b0);
		wr(8'h81, 1'b0);
		foreach (wd[i])
			wr(wd[i], 1'b0);
		ckg_host_model_i.cond(1'b1);
		chk("pins", 24'hf60003, o);
		blk({8'h60, 8'h35, 8'h28, 8'h00, 8'h80, 8'hff, 8'h7f, 8'he1, 8'hb6});
		pdn = 1'b0;
		repeat (8) @(posedge clk);
		#1 chk("pins", 24'h885ffc, o);
		pdn = 1'b1;
		// Second power-up, strap low this time
		arst_n = 1'b0;
		pgood  = 1'b0;
		strap  = 1'b0;
		repeat (12) @(posedge clk);
		#1 arst_n = 1'b1;
		repeat (4) @(posedge clk);
		#1 pgood = 1'b1;
		repeat (8) @(posedge clk);
		#1 chk("pins", 24'h085ffc, o);
		// Block write: count, then byte 0
		ckg_host_model_i.cond(1'b0);
		wr(8'hd2, 1'b0);
		wr(8'h00, 1'b0);
		wr(8'h01, 1'b0);
		wr(8'h10, 1'b0);
		ckg_host_model_i.cond(1'b1);
		// Byte read of byte 0
		ckg_host_model_i.cond(1'b0);
		wr(8'hd2, 1'b0);
		wr(8'h80, 1'b0);
		ckg_host_model_i.cond(1'b0);
		wr(8'hd3, 1'b0);
		rd(8'h30, 1'b1);
		ckg_host_model_i.cond(1'b1);
		chk("pins", 24'h405ffc, o);
		chk("sda_out", 24'h0, {23'h0, sda_out});
		finish_test();
	end
endmodule // ckg_ctrl_regs_test

// ---- bench/ckg_host_model.sv ----
// Two-wire bus host model for the clock generator bank
`timescale 1ns/1ps
module ckg_host_model #(
	parameter int H = 96 // Clocks per bus half period
) (
	// Clock
	input  wire logic clk,
	// Bus lines, data is open drain
	output logic      scl,
	output logic      sda_pull,
	input  wire logic sda_line
);
	// Idle bus: clock high, data released
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	// Wait clocks, then step off the edge
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Data moves mid-low, so no false start or stop
	task automatic bit_x(input logic b, output logic r);
		wt(H / 2);
		sda_pull = ~b;
		wt(H / 2);
		scl = 1'b1;
		wt(H);
		r = sda_line;
		scl = 1'b0;
	endtask
	// Start when s is 0, stop when s is 1
	task automatic cond(input logic s);
		wt(H / 2);
		sda_pull = s;
		wt(H / 2);
		scl = 1'b1;
		wt(H);
		sda_pull = ~s;
		if (!s) begin
			wt(H);
			scl = 1'b0;
		end
	endtask
	// Byte MSB first, then the ninth bit
	task automatic byte_x(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], q[i]);
		bit_x(a, k);
	endtask
endmodule // ckg_host_model

// ---- core/ckg_ctrl_regs.sv ----
// Control and identification register bank of the clock generator, with its serial slave
`timescale 1ns/1ps

// Overview of operation
// - Byte 0 bit 7 shows sampled strap, read-only
// - Byte 0 bit 4 management clock mode, reset 0
// - Byte 0 bit 2 picks SRC root PLL
// - Byte 0 bit 1 picks SATA root source
// - Power-down clears config unless keep bit set
// - Byte 1 bits 6,5 choose spread type
// - Third PLL config applies only when bit2 clear
// - Byte 2 bit 7 enables reference output
// - Byte 4 bits 6..2 enable five outputs
// - Byte 4 bits 1,0 enable PLL spreading
// - Byte 6 bit 5 reference slew middle bit
// - Byte 6 bit 3 27MHz slew middle bit
// - Byte 8 bits 1,0 enable video 27MHz outputs
// - Serial access at D2h, byte or block
// - All registers take defaults at power-up
module ckg_ctrl_regs
	import ckg_pkg::*;
#(
	parameter logic [3:0] REV_CODE  = 4'h3,  // Arbitrary value
	parameter logic [3:0] MAKER_CODE = 4'h5, // Arbitrary value
	parameter logic [3:0] PART_CODE = 4'h6   // Arbitrary value
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	// Serial link pins
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	// Board pins
	input  wire logic       freq_strap,
	input  wire logic       clk_power_good,
	input  wire logic       powerdown_n,
	// Frequency and source controls
	output logic            cpu_freq_is_100,
	output logic            mgmt_clock_mode,
	output logic            src_root_select,
	output logic            sata_root_select,
	output logic            powerdown_keep_config,
	// PLL controls
	output logic            pll_a_spread_type,
	output logic            pll_c_spread_type,
	output logic [3:0]      pll_c_cfg_table,
	output logic            pll_c_cfg_apply,
	output logic            pll_a_spread_enable,
	output logic            pll_c_spread_enable,
	// Output enables
	output logic            refclk_out_enable,
	output logic            sata_clk_out_enable,
	output logic            pcie_ref_out_enable,
	output logic            video96_out_enable,
	output logic            host_clk_b_out_enable,
	output logic            host_clk_a_out_enable,
	output logic            video27_plain_out_enable,
	output logic            video27_spread_out_enable,
	// Slew middle bits
	output logic            refclk_slew_mid,
	output logic            video27_slew_mid
);

	// -------------------------------------------------------------
	// Declarations
	// -------------------------------------------------------------
	localparam ckg_bank_type BANK_RESET = '{
		state: S_IDLE, role: R_ADDR, bitcnt: 4'h0, shreg: 8'h00, ptr: 7'h00,
		byte_mode: 1'b0, tx_count: 1'b0, load_tx: 1'b0, sda_oe: 1'b0, sda_o: 1'b0,
		strap: 1'b0, strap_done: 1'b0, cfg_apply: 1'b1, regs: REG_RESET};

	ckg_bank_type     cur_ff;     // Whole block state
	ckg_bank_type     nxt_ff;     // Its next value
	logic [SYN_W-1:0] syn_s;      // Synchronised pins
	logic [SYN_W-1:0] syn_d;      // Same, one clock later
	logic             scl_rise;   // Clock line went high
	logic             scl_fall;   // Clock line went low
	logic             start_det;  // Data falls while clock high
	logic             stop_det;   // Data rises while clock high
	logic             pd_clear;   // Power-down without keep
	logic             rx_done;    // Eighth bit taken, ack slot begins
	logic             addr_miss;  // Address byte not ours
	logic             wr_fire;    // Data byte lands in a register
	logic             do_load;    // Next transmit byte is loaded
	logic [7:0]       wr_data;    // Byte being written
	logic [7:0]       tx_byte;    // Byte to send next

	// -------------------------------------------------------------
	// Read-back of one byte
	// -------------------------------------------------------------
	// Fixed codes and the strap overlay the stored copy here
	function automatic logic [7:0] rd_byte(input logic [6:0] ofs, input logic [8:0][7:0] regs,
	                                       input logic strap);
		logic [7:0] b;
		b = 8'h00;
		if (ofs < NUM_REGS) begin
			b = regs[ofs[3:0]];
		end
		if (ofs == OFS_FREQ) begin
			b[BIT_FREQ] = strap;
		end
		if (ofs == OFS_IDNT) begin
			b = {REV_CODE, MAKER_CODE};
		end
		if (ofs == OFS_PART) begin
			b[7:PART_LSB] = PART_CODE;
		end
		return b;
	endfunction

	// -------------------------------------------------------------
	// Pin synchronisers
	// -------------------------------------------------------------
	ckg_sync #(
		.W (SYN_W)
	) u_sync (
		.clk      (clk),
		.arst_n   (arst_n),
		.async_in ({clk_power_good, freq_strap, powerdown_n, sda_in, scl_in}),
		.sync_out (syn_s),
		.sync_dly (syn_d)
	);

	// Line events from the settled copies
	assign scl_rise  = syn_s[SYN_SCL] & ~syn_d[SYN_SCL];
	assign scl_fall  = ~syn_s[SYN_SCL] & syn_d[SYN_SCL];
	assign start_det = syn_s[SYN_SCL] & syn_d[SYN_SCL] & syn_d[SYN_SDA] & ~syn_s[SYN_SDA];
	assign stop_det  = syn_s[SYN_SCL] & syn_d[SYN_SCL] & ~syn_d[SYN_SDA] & syn_s[SYN_SDA];
	assign pd_clear  = ~syn_s[SYN_PDN] & ~cur_ff.regs[OFS_FREQ][BIT_KEEP];
	assign rx_done   = (cur_ff.state == S_RX) & scl_fall & (cur_ff.bitcnt == BITS_PER_BYTE);
	assign addr_miss = rx_done & (cur_ff.role == R_ADDR) & (cur_ff.shreg[7:1] != SLV_ADDR);
	assign wr_data   = cur_ff.shreg;
	assign tx_byte   = cur_ff.tx_count ? BLK_RD_COUNT : rd_byte(cur_ff.ptr, cur_ff.regs, cur_ff.strap);

	// -------------------------------------------------------------
	// Next-state logic
	// -------------------------------------------------------------
	always_comb begin
		nxt_ff  = cur_ff;
		wr_fire = 1'b0;
		do_load = 1'b0;
		// One-shot strap capture at first power-good
		if (syn_s[SYN_PGOOD] && !cur_ff.strap_done) begin
			nxt_ff.strap      = syn_s[SYN_STRAP];
			nxt_ff.strap_done = 1'b1;
		end
		// Serial slave sequence
		unique case (cur_ff.state)
			S_IDLE: begin
				nxt_ff.sda_oe = 1'b0;
			end
			S_RX: begin
				if (scl_rise) begin
					// Data is sampled while the clock is high
					nxt_ff.shreg  = {cur_ff.shreg[6:0], syn_s[SYN_SDA]};
					nxt_ff.bitcnt = cur_ff.bitcnt + 4'h1;
				end else if (rx_done) begin
					nxt_ff.bitcnt  = 4'h0;
					nxt_ff.state   = S_ACK_OUT;
					nxt_ff.sda_oe  = 1'b1;
					nxt_ff.load_tx = 1'b0;
					unique case (cur_ff.role)
						R_ADDR: begin
							if (addr_miss) begin
								// Not addressed: stay off the line until next start
								nxt_ff.state  = S_IDLE;
								nxt_ff.sda_oe = 1'b0;
							end else if (cur_ff.shreg[0]) begin
								nxt_ff.load_tx  = 1'b1;
								nxt_ff.tx_count = ~cur_ff.byte_mode;
							end else begin
								nxt_ff.role = R_CMD;
							end
						end
						R_CMD: begin
							// Byte access takes its offset, block access starts at zero
							nxt_ff.byte_mode = cur_ff.shreg[CMD_BYTE_BIT];
							nxt_ff.ptr  = cur_ff.shreg[CMD_BYTE_BIT] ? cur_ff.shreg[6:0] : 7'h00;
							nxt_ff.role = cur_ff.shreg[CMD_BYTE_BIT] ? R_DATA : R_COUNT;
						end
						R_COUNT: begin
							// Block count is acknowledged and not needed
							nxt_ff.role = R_DATA;
						end
						R_DATA: begin
							wr_fire    = 1'b1;
							nxt_ff.ptr = cur_ff.ptr + 7'h01;
						end
					endcase
				end
			end
			S_ACK_OUT: begin
				if (scl_fall) begin
					nxt_ff.sda_oe = 1'b0;
					if (cur_ff.load_tx) begin
						do_load = 1'b1;
					end else begin
						nxt_ff.state  = S_RX;
						nxt_ff.bitcnt = 4'h0;
					end
				end
			end
			S_TX: begin
				if (scl_fall) begin
					if (cur_ff.bitcnt == BITS_PER_BYTE) begin
						// Release for the master's acknowledge
						nxt_ff.sda_oe = 1'b0;
						nxt_ff.state  = S_ACK_IN;
						nxt_ff.bitcnt = 4'h0;
					end else begin
						nxt_ff.sda_oe = ~cur_ff.shreg[7];
						nxt_ff.shreg  = {cur_ff.shreg[6:0], 1'b0};
						nxt_ff.bitcnt = cur_ff.bitcnt + 4'h1;
					end
				end
			end
			S_ACK_IN: begin
				if (scl_rise) begin
					// Not acknowledged ends the read
					if (syn_s[SYN_SDA]) begin
						nxt_ff.state = S_IDLE;
					end else begin
						nxt_ff.bitcnt = ACKED_MARK;
					end
				end else if (scl_fall && cur_ff.bitcnt == ACKED_MARK) begin
					do_load = 1'b1;
				end
			end
			default: begin
				nxt_ff.state  = S_IDLE;
				nxt_ff.sda_oe = 1'b0;
			end
		endcase
		// Load a transmit byte and put its first bit out
		if (do_load) begin
			nxt_ff.state  = S_TX;
			nxt_ff.sda_oe = ~tx_byte[7];
			nxt_ff.shreg  = {tx_byte[6:0], 1'b0};
			nxt_ff.bitcnt = 4'h1;
			if (cur_ff.tx_count) begin
				nxt_ff.tx_count = 1'b0;
			end else begin
				nxt_ff.ptr = cur_ff.ptr + 7'h01;
			end
		end
		// Start and stop override any phase; repeated start keeps the offset
		if (start_det) begin
			nxt_ff.state  = S_RX;
			nxt_ff.role   = R_ADDR;
			nxt_ff.bitcnt = 4'h0;
			nxt_ff.sda_oe = 1'b0;
		end else if (stop_det) begin
			nxt_ff.state  = S_IDLE;
			nxt_ff.sda_oe = 1'b0;
		end
		// Only writable bits change; reserved ones keep power-up values
		if (wr_fire && cur_ff.ptr < NUM_REGS) begin
			nxt_ff.regs[cur_ff.ptr[3:0]] = (cur_ff.regs[cur_ff.ptr[3:0]] & ~REG_WMASK[cur_ff.ptr[3:0]]) |
			                               (wr_data & REG_WMASK[cur_ff.ptr[3:0]]);
		end
		// Power-down without keep drops back to defaults, writes lose
		if (pd_clear) begin
			nxt_ff.regs = REG_RESET;
		end
		// Config field is live only with the first PLL as SRC root
		nxt_ff.cfg_apply = ~nxt_ff.regs[OFS_FREQ][BIT_SRCSEL];
	end

	// State register; defaults loaded at power-up
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cur_ff <= BANK_RESET;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	// -------------------------------------------------------------
	// Outputs, all straight from the state register
	// -------------------------------------------------------------
	assign sda_out                   = cur_ff.sda_o;
	assign sda_oe                    = cur_ff.sda_oe;
	assign cpu_freq_is_100           = cur_ff.strap;
	assign mgmt_clock_mode           = cur_ff.regs[OFS_FREQ][BIT_MGMT];
	assign src_root_select           = cur_ff.regs[OFS_FREQ][BIT_SRCSEL];
	assign sata_root_select          = cur_ff.regs[OFS_FREQ][BIT_SATSEL];
	assign powerdown_keep_config     = cur_ff.regs[OFS_FREQ][BIT_KEEP];
	assign pll_a_spread_type         = cur_ff.regs[OFS_SPRD][BIT_ASPT];
	assign pll_c_spread_type         = cur_ff.regs[OFS_SPRD][BIT_CSPT];
	assign pll_c_cfg_table           = cur_ff.regs[OFS_SPRD][CFG_MSB:CFG_LSB];
	assign pll_c_cfg_apply           = cur_ff.cfg_apply;
	assign refclk_out_enable         = cur_ff.regs[OFS_REFE][BIT_REFOE];
	assign sata_clk_out_enable       = cur_ff.regs[OFS_OUTE][OE_MSB];
	assign pcie_ref_out_enable       = cur_ff.regs[OFS_OUTE][OE_MSB-1];
	assign video96_out_enable        = cur_ff.regs[OFS_OUTE][OE_MSB-2];
	assign host_clk_b_out_enable     = cur_ff.regs[OFS_OUTE][OE_MSB-3];
	assign host_clk_a_out_enable     = cur_ff.regs[OFS_OUTE][OE_MSB-4];
	assign pll_a_spread_enable       = cur_ff.regs[OFS_OUTE][OE_MSB-5];
	assign pll_c_spread_enable       = cur_ff.regs[OFS_OUTE][OE_MSB-6];
	assign refclk_slew_mid           = cur_ff.regs[OFS_SLEW][BIT_REFSL];
	assign video27_slew_mid          = cur_ff.regs[OFS_SLEW][BIT_V27SL];
	assign video27_plain_out_enable  = cur_ff.regs[OFS_PART][BIT_V27P];
	assign video27_spread_out_enable = cur_ff.regs[OFS_PART][BIT_V27S];

	// -------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	property p_strap_catch;
		syn_s[SYN_PGOOD] && !cur_ff.strap_done |=> cpu_freq_is_100 == $past(syn_s[SYN_STRAP]);
	endproperty
	a_strap_catch: assert property (p_strap_catch) else $error("strap not caught");

	property p_strap_hold;
		cur_ff.strap_done |=> cur_ff.strap_done && $stable(cpu_freq_is_100) && {7'h00, cpu_freq_is_100}
		                      == (rd_byte(OFS_FREQ, cur_ff.regs, cur_ff.strap) >> BIT_FREQ);
	endproperty
	a_strap_hold: assert property (p_strap_hold) else $error("strap changed");

	property p_byte0_write;
		wr_fire && !pd_clear && cur_ff.ptr == OFS_FREQ |=>
			mgmt_clock_mode == $past(wr_data[BIT_MGMT]) && src_root_select == $past(wr_data[BIT_SRCSEL])
			&& sata_root_select == $past(wr_data[BIT_SATSEL]);
	endproperty
	a_byte0_write: assert property (p_byte0_write) else $error("byte 0 write lost");

	property p_cfg_apply;
		pll_c_cfg_apply != src_root_select;
	endproperty
	a_cfg_apply: assert property (p_cfg_apply) else $error("config apply wrong");

	property p_pd_clear;
		pd_clear |=> cur_ff.regs == REG_RESET;
	endproperty
	a_pd_clear: assert property (p_pd_clear) else $error("config not cleared");

	property p_pd_keep;
		!syn_s[SYN_PDN] && powerdown_keep_config && !wr_fire |=> $stable(cur_ff.regs);
	endproperty
	a_pd_keep: assert property (p_pd_keep) else $error("kept config changed");

	property p_byte1_write;
		wr_fire && !pd_clear && cur_ff.ptr == OFS_SPRD |=> pll_a_spread_type == $past(wr_data[BIT_ASPT])
			&& pll_c_spread_type == $past(wr_data[BIT_CSPT]) && pll_c_cfg_table == $past(wr_data[CFG_MSB:CFG_LSB]);
	endproperty
	a_byte1_write: assert property (p_byte1_write) else $error("byte 1 write lost");

	property p_oe_write;
		wr_fire && !pd_clear && cur_ff.ptr == OFS_OUTE |=>
			{sata_clk_out_enable, pcie_ref_out_enable, video96_out_enable, host_clk_b_out_enable,
			 host_clk_a_out_enable, pll_a_spread_enable, pll_c_spread_enable} == $past(wr_data[OE_MSB:0]);
	endproperty
	a_oe_write: assert property (p_oe_write) else $error("byte 4 write lost");

	property p_misc_write;
		wr_fire && !pd_clear && (cur_ff.ptr == OFS_SLEW || cur_ff.ptr == OFS_PART || cur_ff.ptr == OFS_REFE) |=>
			cur_ff.regs[$past(cur_ff.ptr[3:0])] == ((REG_RESET[$past(cur_ff.ptr[3:0])] & ~REG_WMASK[$past(cur_ff.ptr[3:0])])
			| ($past(wr_data) & REG_WMASK[$past(cur_ff.ptr[3:0])]));
	endproperty
	a_misc_write: assert property (p_misc_write) else $error("byte write lost");

	property p_fixed_codes;
		rd_byte(OFS_IDNT, cur_ff.regs, cur_ff.strap) == {REV_CODE, MAKER_CODE}
		&& (rd_byte(OFS_PART, cur_ff.regs, cur_ff.strap) >> PART_LSB) == {4'h0, PART_CODE};
	endproperty
	a_fixed_codes: assert property (p_fixed_codes) else $error("fixed code wrong");

	property p_reserved;
		((cur_ff.regs ^ REG_RESET) & ~REG_WMASK) == '0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit moved");

	property p_addr_miss;
		addr_miss |=> !sda_oe && cur_ff.state == S_IDLE;
	endproperty
	a_addr_miss: assert property (p_addr_miss) else $error("foreign address acked");

	property p_cmd_decode;
		rx_done && cur_ff.role == R_CMD |=>
			cur_ff.ptr == ($past(cur_ff.shreg[CMD_BYTE_BIT]) ? $past(cur_ff.shreg[6:0]) : 7'h00);
	endproperty
	a_cmd_decode: assert property (p_cmd_decode) else $error("command decode wrong");

	c_block_write: cover property (wr_fire && !cur_ff.byte_mode ##[1:1000] wr_fire);
	c_byte_read:   cover property (do_load && cur_ff.byte_mode);
	c_nack:        cover property (cur_ff.state == S_ACK_IN && scl_rise && syn_s[SYN_SDA]);
	c_pd_clear:    cover property (pd_clear && cur_ff.regs != REG_RESET);

endmodule // ckg_ctrl_regs

// ---- core/ckg_sync.sv ----
// Two-stage synchroniser with one extra delayed copy for edge detection
`timescale 1ns/1ps

module ckg_sync #(
	parameter int W = 5
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         arst_n,
	// Asynchronous inputs
	input  wire logic [W-1:0] async_in,
	// Synchronised and delayed copies
	output logic      [W-1:0] sync_out,
	output logic      [W-1:0] sync_dly
);

	// -------------------------------------------------------------
	// State
	// -------------------------------------------------------------
	typedef struct packed {
		logic [W-1:0] meta;  // First stage, read only by second
		logic [W-1:0] sync;  // Second stage
		logic [W-1:0] dly;   // Copy one clock later
	} ckg_sync_type;

	ckg_sync_type cur_ff;
	ckg_sync_type nxt_ff;

	// Shift every stage along
	always_comb begin
		nxt_ff      = cur_ff;
		nxt_ff.meta = async_in;
		nxt_ff.sync = cur_ff.meta;
		nxt_ff.dly  = cur_ff.sync;
	end

	// Constant reset only; the pins are caught after release
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	assign sync_out = cur_ff.sync;
	assign sync_dly = cur_ff.dly;

endmodule // ckg_sync

// ---- include/ckg_pkg.sv ----
// Shared constants, register map and types of the clock generator control bank
package ckg_pkg;

	// -------------------------------------------------------------
	// Serial link constants
	// -------------------------------------------------------------
	localparam logic [6:0] SLV_ADDR      = 7'h69;   // Eight-bit form 0xd2 without the direction bit
	localparam int         CMD_BYTE_BIT  = 7;       // Command bit choosing single-byte access
	localparam logic [7:0] BLK_RD_COUNT  = 8'h0f;   // Count sent first on a block read
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;    // Data bits before each acknowledge
	localparam logic [3:0] ACKED_MARK    = 4'h9;    // Bit counter value after master acknowledge

	// -------------------------------------------------------------
	// Register offsets
	// -------------------------------------------------------------
	localparam logic [6:0] NUM_REGS = 7'h09;        // Implemented bytes 0 to 8
	localparam logic [6:0] OFS_FREQ = 7'h00;        // freq_and_source_control
	localparam logic [6:0] OFS_SPRD = 7'h01;        // spread_type_and_pll_config
	localparam logic [6:0] OFS_REFE = 7'h02;        // refclk_enable_control
	localparam logic [6:0] OFS_RSV3 = 7'h03;        // reserved_control_three
	localparam logic [6:0] OFS_OUTE = 7'h04;        // output_and_spread_enables
	localparam logic [6:0] OFS_RSV5 = 7'h05;        // reserved_control_five
	localparam logic [6:0] OFS_SLEW = 7'h06;        // slew_middle_bits
	localparam logic [6:0] OFS_IDNT = 7'h07;        // revision_and_maker_code
	localparam logic [6:0] OFS_PART = 7'h08;        // part_code_and_video_enables

	// -------------------------------------------------------------
	// Field positions
	// -------------------------------------------------------------
	localparam int BIT_FREQ   = 7;                  // Byte 0: sampled frequency strap
	localparam int BIT_MGMT   = 4;                  // Byte 0: management clock mode
	localparam int BIT_SRCSEL = 2;                  // Byte 0: SRC root source
	localparam int BIT_SATSEL = 1;                  // Byte 0: SATA root source
	localparam int BIT_KEEP   = 0;                  // Byte 0: keep config at power-down
	localparam int BIT_ASPT   = 6;                  // Byte 1: first PLL spread type
	localparam int BIT_CSPT   = 5;                  // Byte 1: third PLL spread type
	localparam int CFG_MSB    = 4;                  // Byte 1: third PLL config field top
	localparam int CFG_LSB    = 1;                  // Byte 1: third PLL config field bottom
	localparam int BIT_REFOE  = 7;                  // Byte 2: reference output enable
	localparam int OE_MSB     = 6;                  // Byte 4: SATA enable down to spread enables
	localparam int BIT_REFSL  = 5;                  // Byte 6: reference slew middle bit
	localparam int BIT_V27SL  = 3;                  // Byte 6: 27MHz slew middle bit
	localparam int PART_LSB   = 4;                  // Byte 8: part code nibble bottom
	localparam int BIT_V27P   = 1;                  // Byte 8: plain 27MHz enable
	localparam int BIT_V27S   = 0;                  // Byte 8: spread 27MHz enable

	// -------------------------------------------------------------
	// Power-up values and writable masks, byte 8 first
	// -------------------------------------------------------------
	localparam logic [8:0][7:0] REG_RESET = {8'h03, 8'h00, 8'h00, 8'h00, 8'hff,
	                                         8'hff, 8'hff, 8'h85, 8'h21};
	localparam logic [8:0][7:0] REG_WMASK = {8'h03, 8'h00, 8'h28, 8'h00, 8'h7f,
	                                         8'h00, 8'h80, 8'h7e, 8'h17};

	// -------------------------------------------------------------
	// Synchroniser lanes
	// -------------------------------------------------------------
	localparam int SYN_W     = 5;
	localparam int SYN_SCL   = 0;
	localparam int SYN_SDA   = 1;
	localparam int SYN_PDN   = 2;
	localparam int SYN_STRAP = 3;
	localparam int SYN_PGOOD = 4;

	// -------------------------------------------------------------
	// Types
	// -------------------------------------------------------------
	typedef enum logic [2:0] {
		S_IDLE    = 3'b000,
		S_RX      = 3'b001,
		S_ACK_OUT = 3'b010,
		S_TX      = 3'b011,
		S_ACK_IN  = 3'b100
	} ckg_state_type;

	typedef enum logic [1:0] {
		R_ADDR  = 2'b00,
		R_CMD   = 2'b01,
		R_COUNT = 2'b10,
		R_DATA  = 2'b11
	} ckg_role_type;

	typedef struct packed {
		ckg_state_type   state;
		ckg_role_type    role;
		logic [3:0]      bitcnt;
		logic [7:0]      shreg;
		logic [6:0]      ptr;
		logic            byte_mode;
		logic            tx_count;
		logic            load_tx;
		logic            sda_oe;
		logic            sda_o;
		logic            strap;
		logic            strap_done;
		logic            cfg_apply;
		logic [8:0][7:0] regs;
	} ckg_bank_type;

endpackage
